// ### lshu_pkg.sv
// Purpose: constants and types for the limit switch and homing unit
// Assumes: 40 MHz core clock, AHB-Lite register access, five switch inputs
// Notes: register offsets are byte addresses of aligned 32-bit words
// What this block does
// - every mask holds one bit per input, set or cleared individually
// - fault pin is mask bit 1, fourth input is mask bit 3
// - polarity bit 1 means rising edge/high active, 0 falling edge/low active
// - hard blocking acts only on inputs set in the blocking mask
// - blocked direction bit 1 blocks clockwise, 0 blocks anticlockwise
// - active blocking switch inhibits its blocked direction, allows moving out
// - a target velocity toward a blocked direction is held at zero
// - homing zero mask zeroes position on active edge during homing
// - homing stop mask stops motor on active edge during homing
// - homing notify mask sends one notify character on active edge during homing
// - switch already active at start: drive out opposite homing direction first
// - signed homing speed: magnitude is rpm, sign is direction
// - direct zero arm zeroes position on edge then clears its bit
// - direct stop stops motor on edge then clears its bit
// - direct notify sends character on edge then clears its bit
// - direct action stays pending until edge; a new write replaces it
// - direct masks are cleared after power-on
// - positioning mode stop returns to captured reference at max acceleration
// - velocity mode stop decelerates at set deceleration, no repositioning
// - notify characters h, f, t, w, x for inputs 0 to 4
// - setup command copies direct masks into homing masks
// - analog and fault inputs edge detected; others need 500 us stable level
// - fault pin limit functions only accepted when configured as reference
package lshu_pkg;
   localparam int unsigned NUM_IN = 5;
   localparam logic [7:0] OFS_POLARITY = 8'h00;
   localparam logic [7:0] OFS_BLOCK = 8'h04;
   localparam logic [7:0] OFS_BLKDIR = 8'h08;
   localparam logic [7:0] OFS_HZERO = 8'h0C;
   localparam logic [7:0] OFS_HSTOP = 8'h10;
   localparam logic [7:0] OFS_HNOTIFY = 8'h14;
   localparam logic [7:0] OFS_DZERO = 8'h18;
   localparam logic [7:0] OFS_DSTOP = 8'h1C;
   localparam logic [7:0] OFS_DNOTIFY = 8'h20;
   localparam logic [7:0] OFS_HSPEED = 8'h24;
   localparam logic [7:0] OFS_CTRL = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2C;
   localparam logic [7:0] OFS_CMD = 8'h30;
   localparam logic [7:0] OFS_TARGET = 8'h34;
   // ctrl bits
   localparam int unsigned CTRL_FAULT_REF = 0;
   localparam int unsigned CTRL_POSMODE = 1;
   // cmd bits (write-only pulses)
   localparam int unsigned CMD_START = 0;
   localparam int unsigned CMD_SETUP = 1;
   localparam logic [4:0] MASK_RESET = 5'h00;
   localparam logic [15:0] SPEED_RESET = 16'h0000;
   localparam int unsigned STABLE_US = 500;
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned STABLE_CYC = STABLE_US * CLK_MHZ;
   localparam logic [7:0] CH_ANALOG = 8'h68;
   localparam logic [7:0] CH_FAULT = 8'h66;
   localparam logic [7:0] CH_THIRD = 8'h74;
   localparam logic [7:0] CH_FOURTH = 8'h77;
   localparam logic [7:0] CH_FIFTH = 8'h78;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_LEAVE = 2'b01,
      HS_SEEK = 2'b11
   } lshu_home_e;
   typedef enum logic [1:0] {
      MC_RUN = 2'b00,
      MC_REPOS = 2'b01,
      MC_DECEL = 2'b10
   } lshu_mot_e;
   typedef struct packed {
      logic zero_pos;
      logic stop;
      logic [1:0] stop_kind;
      logic [7:0] notify_char;
      logic notify_valid;
   } lshu_evt_s;
endpackage

// ### lshu_top.sv
// Purpose: switch conditioning, hard blocking, armed edge actions, homing run
// Assumes: one AHB-Lite master, single word transfers, switches asynchronous
// Notes: zero wait states; notify characters are one-cycle strobes to the serial unit
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lshu_top #(
   parameter int unsigned STABLE_CYCLES = lshu_pkg::STABLE_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic [4:0] i_switch,
   output logic o_zero_pos,
   output logic o_stop,
   output logic o_stop_repos,
   output logic o_notify_valid,
   output logic [7:0] o_notify_char,
   output logic [15:0] o_cmd_speed,
   output logic o_cmd_cw,
   output logic o_homing_busy
);
   localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
   if (STABLE_CYCLES < 1) begin : g_bad_stable
      $error("stable count must be at least one");
   end

   logic [4:0] pol_q, blk_q, bdir_q, hz_q, hs_q, hnt_q, dz_q, ds_q, dn_q;
   logic [15:0] hspeed_q, target_q;
   logic [1:0] ctrl_q;
   // bus
   logic wr_pend_q, rd_pend_q;
   logic [7:0] addr_q;
   logic start_p, setup_p;
   wire logic take = i_hsel && i_hready && i_htrans[1];

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_pend_q <= take && i_hwrite;
         rd_pend_q <= take && !i_hwrite;
         if (take) begin
            addr_q <= i_haddr[7:0];
         end
      end
   end

   wire logic wr = wr_pend_q;
   assign start_p = wr && addr_q == lshu_pkg::OFS_CMD && i_hwdata[lshu_pkg::CMD_START];
   assign setup_p = wr && addr_q == lshu_pkg::OFS_CMD && i_hwdata[lshu_pkg::CMD_SETUP];

   // synchroniser: three stages, change accepted when 2nd and 3rd agree
   logic [4:0] s1_q, s2_q, s3_q, lvl_q, lvl_prev_q;
   logic [CW-1:0] cnt_q [4:0];
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= 5'h00;
         s2_q <= 5'h00;
         s3_q <= 5'h00;
      end else begin
         s1_q <= i_switch;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // analog and fault pins act on edges; slow inputs need a steady level first
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         lvl_q <= 5'h00;
         for (int i = 0; i < 5; i++) cnt_q[i] <= '0;
      end else begin
         for (int i = 0; i < 5; i++) begin
            if (i < 2) begin
               if (s2_q[i] == s3_q[i]) lvl_q[i] <= s3_q[i];
            end else if (s2_q[i] != s3_q[i] || s3_q[i] == lvl_q[i]) begin
               cnt_q[i] <= '0;
            end else if (cnt_q[i] == CW'(STABLE_CYCLES - 1)) begin
               lvl_q[i] <= s3_q[i];
               cnt_q[i] <= '0;
            end else begin
               cnt_q[i] <= cnt_q[i] + CW'(1);
            end
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) lvl_prev_q <= 5'h00;
      else lvl_prev_q <= lvl_q;
   end

   // fault pin ignored unless configured as reference
   wire logic [4:0] allow = {3'b111, ctrl_q[lshu_pkg::CTRL_FAULT_REF], 1'b1};
   wire logic [4:0] active = ~(lvl_q ^ pol_q) & allow;
   wire logic [4:0] act_prev = ~(lvl_prev_q ^ pol_q) & allow;
   wire logic [4:0] edge_hit = active & ~act_prev;

   // magnitude of a signed speed word; the most negative value wraps to itself
   function automatic logic [15:0] mag16(input logic [15:0] v);
      return v[15] ? 16'(-v) : v;
   endfunction

   // homing sequencer
   lshu_pkg::lshu_home_e hstate_q;
   logic [4:0] hsel;
   assign hsel = hz_q | hs_q | hnt_q;
   wire logic home_neg = hspeed_q[15];
   wire logic [15:0] home_mag = mag16(hspeed_q);
   wire logic seeking = hstate_q == lshu_pkg::HS_SEEK;
   wire logic [4:0] h_hit = seeking ? (edge_hit & hsel) : 5'h00;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         hstate_q <= lshu_pkg::HS_IDLE;
      end else begin
         case (hstate_q)
            lshu_pkg::HS_IDLE: begin
               // a start with nothing configured does nothing
               if (start_p && hsel != 5'h00) begin
                  hstate_q <= |(active & hsel) ? lshu_pkg::HS_LEAVE : lshu_pkg::HS_SEEK;
               end
            end
            lshu_pkg::HS_LEAVE: begin
               if (!(|(active & hsel))) hstate_q <= lshu_pkg::HS_SEEK;
            end
            lshu_pkg::HS_SEEK: begin
               if (|(h_hit & hs_q)) hstate_q <= lshu_pkg::HS_IDLE;
            end
            default: hstate_q <= lshu_pkg::HS_IDLE;
         endcase
      end
   end

   // direct masks, homing masks and config; a write wins over an event, event clears
   wire logic [4:0] wd = i_hwdata[4:0];
   wire logic [4:0] d_zero_hit = edge_hit & dz_q;
   wire logic [4:0] d_stop_hit = edge_hit & ds_q;
   wire logic [4:0] d_ntf_hit = edge_hit & dn_q;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         dz_q <= lshu_pkg::MASK_RESET;
         ds_q <= lshu_pkg::MASK_RESET;
         dn_q <= lshu_pkg::MASK_RESET;
      end else begin
         // a fresh write replaces the pending arming
         if (wr && addr_q == lshu_pkg::OFS_DZERO) dz_q <= wd;
         else dz_q <= dz_q & ~d_zero_hit;
         if (wr && addr_q == lshu_pkg::OFS_DSTOP) ds_q <= wd;
         else ds_q <= ds_q & ~d_stop_hit;
         if (wr && addr_q == lshu_pkg::OFS_DNOTIFY) dn_q <= wd;
         else dn_q <= dn_q & ~d_ntf_hit;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pol_q <= lshu_pkg::MASK_RESET;
         blk_q <= lshu_pkg::MASK_RESET;
         bdir_q <= lshu_pkg::MASK_RESET;
         hz_q <= lshu_pkg::MASK_RESET;
         hs_q <= lshu_pkg::MASK_RESET;
         hnt_q <= lshu_pkg::MASK_RESET;
         hspeed_q <= lshu_pkg::SPEED_RESET;
         target_q <= lshu_pkg::SPEED_RESET;
         ctrl_q <= 2'b00;
      end else if (setup_p) begin
         hz_q <= dz_q;
         hs_q <= ds_q;
         hnt_q <= dn_q;
      end else if (wr) begin
         case (addr_q)
            lshu_pkg::OFS_POLARITY: pol_q <= wd;
            lshu_pkg::OFS_BLOCK: blk_q <= wd;
            lshu_pkg::OFS_BLKDIR: bdir_q <= wd;
            lshu_pkg::OFS_HZERO: hz_q <= wd;
            lshu_pkg::OFS_HSTOP: hs_q <= wd;
            lshu_pkg::OFS_HNOTIFY: hnt_q <= wd;
            lshu_pkg::OFS_HSPEED: hspeed_q <= i_hwdata[15:0];
            lshu_pkg::OFS_TARGET: target_q <= i_hwdata[15:0];
            lshu_pkg::OFS_CTRL: ctrl_q <= i_hwdata[1:0];
            default: ctrl_q <= ctrl_q;
         endcase
      end
   end

   // blocking and velocity command
   wire logic [4:0] blk_act = active & blk_q;
   wire logic cw_blocked = |(blk_act & bdir_q);
   wire logic ccw_blocked = |(blk_act & ~bdir_q);
   logic req_cw;
   logic [15:0] req_mag;
   always_comb begin
      req_cw = !target_q[15];
      req_mag = mag16(target_q);
      if (hstate_q == lshu_pkg::HS_LEAVE) begin
         req_cw = home_neg;
         req_mag = home_mag;
      end else if (seeking) begin
         req_cw = !home_neg;
         req_mag = home_mag;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cmd_speed <= 16'h0000;
         o_cmd_cw <= 1'b0;
      end else begin
         o_cmd_cw <= req_cw;
         if ((req_cw && cw_blocked) || (!req_cw && ccw_blocked)) o_cmd_speed <= 16'h0000;
         else o_cmd_speed <= req_mag;
      end
   end

   function automatic logic [7:0] ntf_char(input logic [4:0] m);
      logic [7:0] c;
      c = 8'h00;
      if (m[0]) c = lshu_pkg::CH_ANALOG;
      else if (m[1]) c = lshu_pkg::CH_FAULT;
      else if (m[2]) c = lshu_pkg::CH_THIRD;
      else if (m[3]) c = lshu_pkg::CH_FOURTH;
      else if (m[4]) c = lshu_pkg::CH_FIFTH;
      return c;
   endfunction

   wire logic [4:0] ntf_hits = d_ntf_hit | (h_hit & hnt_q);
   wire logic stop_ev = |d_stop_hit || |(h_hit & hs_q);

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_zero_pos <= 1'b0;
         o_stop <= 1'b0;
         o_stop_repos <= 1'b0;
         o_notify_valid <= 1'b0;
         o_notify_char <= 8'h00;
         o_homing_busy <= 1'b0;
      end else begin
         o_zero_pos <= |d_zero_hit || |(h_hit & hz_q);
         o_stop <= stop_ev && !ctrl_q[lshu_pkg::CTRL_POSMODE];
         o_stop_repos <= stop_ev && ctrl_q[lshu_pkg::CTRL_POSMODE];
         o_notify_valid <= |ntf_hits;
         o_notify_char <= ntf_char(ntf_hits);
         o_homing_busy <= hstate_q != lshu_pkg::HS_IDLE;
      end
   end

   // read mux
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hrdata <= 32'h0000_0000;
      end else if (take && !i_hwrite) begin
         case (i_haddr[7:0])
            lshu_pkg::OFS_POLARITY: o_hrdata <= {27'h0, pol_q};
            lshu_pkg::OFS_BLOCK: o_hrdata <= {27'h0, blk_q};
            lshu_pkg::OFS_BLKDIR: o_hrdata <= {27'h0, bdir_q};
            lshu_pkg::OFS_HZERO: o_hrdata <= {27'h0, hz_q};
            lshu_pkg::OFS_HSTOP: o_hrdata <= {27'h0, hs_q};
            lshu_pkg::OFS_HNOTIFY: o_hrdata <= {27'h0, hnt_q};
            lshu_pkg::OFS_DZERO: o_hrdata <= {27'h0, dz_q};
            lshu_pkg::OFS_DSTOP: o_hrdata <= {27'h0, ds_q};
            lshu_pkg::OFS_DNOTIFY: o_hrdata <= {27'h0, dn_q};
            lshu_pkg::OFS_HSPEED: o_hrdata <= {16'h0, hspeed_q};
            lshu_pkg::OFS_TARGET: o_hrdata <= {16'h0, target_q};
            lshu_pkg::OFS_CTRL: o_hrdata <= {30'h0, ctrl_q};
            lshu_pkg::OFS_STATUS: o_hrdata <= {20'h0, cw_blocked, ccw_blocked, hstate_q,
                                               3'h0, active};
            default: o_hrdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
   end

   property p_block_zero;
      @(posedge i_core_clk) disable iff (i_rst)
      (req_cw && cw_blocked) |=> o_cmd_speed == 16'h0000;
   endproperty
   a_block_zero: assert property (p_block_zero) else $error("blocked cw not held at zero");

   property p_dz_clear;
      @(posedge i_core_clk) disable iff (i_rst)
      (|d_zero_hit && !wr) |=> ((dz_q & $past(d_zero_hit)) == 5'h00) && o_zero_pos;
   endproperty
   a_dz_clear: assert property (p_dz_clear) else $error("direct zero not single shot");

   property p_ds_clear;
      @(posedge i_core_clk) disable iff (i_rst)
      (|d_stop_hit && !wr) |=> (o_stop || o_stop_repos) && (ds_q & $past(d_stop_hit)) == 5'h00;
   endproperty
   a_ds_clear: assert property (p_ds_clear) else $error("direct stop not single shot");

   property p_notify;
      @(posedge i_core_clk) disable iff (i_rst)
      d_ntf_hit[1] && !d_ntf_hit[0] |=> o_notify_valid && o_notify_char == 8'h66;
   endproperty
   a_notify: assert property (p_notify) else $error("fault notify char wrong");

   property p_fault_ref;
      @(posedge i_core_clk) disable iff (i_rst)
      !ctrl_q[lshu_pkg::CTRL_FAULT_REF] |-> !edge_hit[1];
   endproperty
   a_fault_ref: assert property (p_fault_ref) else $error("fault pin acted without ref");

   property p_leave;
      @(posedge i_core_clk) disable iff (i_rst)
      (hstate_q == lshu_pkg::HS_IDLE && start_p && |(active & hsel))
         |=> hstate_q == lshu_pkg::HS_LEAVE ##1 o_cmd_cw == home_neg || o_cmd_speed == 16'h0000;
   endproperty
   a_leave: assert property (p_leave) else $error("homing did not leave switch");

   property p_hstop;
      @(posedge i_core_clk) disable iff (i_rst)
      |(h_hit & hs_q) |=> hstate_q == lshu_pkg::HS_IDLE && !$past(o_homing_busy, 1) == 1'b0;
   endproperty
   a_hstop: assert property (p_hstop) else $error("homing stop did not end run");

   property p_posmode;
      @(posedge i_core_clk) disable iff (i_rst)
      o_stop_repos |-> !o_stop && $past(ctrl_q[lshu_pkg::CTRL_POSMODE]);
   endproperty
   a_posmode: assert property (p_posmode) else $error("repositioning outside positioning");

   property p_dn_clear;
      @(posedge i_core_clk) disable iff (i_rst)
      (|d_ntf_hit && !wr) |=> o_notify_valid && (dn_q & $past(d_ntf_hit)) == 5'h00;
   endproperty
   a_dn_clear: assert property (p_dn_clear) else $error("direct notify repeated");

   property p_ccw_zero;
      @(posedge i_core_clk) disable iff (i_rst)
      (!req_cw && ccw_blocked) |=> o_cmd_speed == 16'h0000;
   endproperty
   a_ccw_zero: assert property (p_ccw_zero) else $error("blocked ccw not held at zero");

   property p_home_zero;
      @(posedge i_core_clk) disable iff (i_rst)
      |(h_hit & hz_q) |=> o_zero_pos;
   endproperty
   a_home_zero: assert property (p_home_zero) else $error("no homing zero");

   property p_home_notify;
      @(posedge i_core_clk) disable iff (i_rst)
      |(h_hit & hnt_q) |=> o_notify_valid;
   endproperty
   a_home_notify: assert property (p_home_notify) else $error("no homing notify");

   property p_vel_stop;
      @(posedge i_core_clk) disable iff (i_rst)
      (stop_ev && !ctrl_q[lshu_pkg::CTRL_POSMODE]) |=> o_stop && !o_stop_repos;
   endproperty
   a_vel_stop: assert property (p_vel_stop) else $error("velocity stop wrong kind");

   property p_seek_dir;
      @(posedge i_core_clk) disable iff (i_rst)
      seeking |=> o_cmd_cw == !$past(home_neg);
   endproperty
   a_seek_dir: assert property (p_seek_dir) else $error("homing direction wrong");
endmodule // lshu_top
`default_nettype wire

// ### lshu_sw_model.sv
// Purpose: far side model: switch pins and the serial host catching notify chars
// Assumes: pins change just after a rising edge; chars are one-cycle strobes
// Notes: switches are levels the bench sets through set_pin
`timescale 1ns/1ps
`default_nettype none
module lshu_sw_model (
   input wire logic i_core_clk,
   input wire logic i_notify_valid,
   input wire logic [7:0] i_notify_char,
   output logic [4:0] o_switch = 5'h00,
   output logic [31:0] o_char_count = 32'h0000_0000,
   output logic [7:0] o_last_char = 8'h00
);
   task automatic set_pin(input int idx, input logic lvl);
      @(posedge i_core_clk);
      o_switch[idx] <= lvl;
   endtask
   // host takes a char only in the strobe cycle
   always @(posedge i_core_clk) begin
      if (i_notify_valid === 1'b1) begin
         o_char_count <= o_char_count + 32'h0000_0001;
         o_last_char <= i_notify_char;
      end
   end
endmodule // lshu_sw_model
`default_nettype wire

// ### lshu_tb.sv
// Purpose: self-checking bench for the limit switch and homing unit
// Assumes: zero wait state slave, STABLE_CYCLES shortened to 4
// Notes: waits of 30 cycles cover the 3-flop sync plus the stable count
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, cnt_zero = 32'h0, cnt_stop = 32'h0;
   logic [31:0] cnt_repos = 32'h0, chars, rdv;
   logic [1:0] htrans = 2'b00;
   logic hready, hresp, zero_pos, stop, repos, nvalid, cmd_cw, busy;
   logic [7:0] nchar, last_char;
   logic [15:0] cmd_speed;
   logic [4:0] sw;
   int errors = 0, samples_checked = 0, cycles = 0;
   lshu_top #(.STABLE_CYCLES(4)) u_lshu_top (.i_core_clk(clk), .i_rst(rst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
      .i_switch(sw), .o_zero_pos(zero_pos), .o_stop(stop), .o_stop_repos(repos),
      .o_notify_valid(nvalid), .o_notify_char(nchar), .o_cmd_speed(cmd_speed),
      .o_cmd_cw(cmd_cw), .o_homing_busy(busy));
   lshu_sw_model u_lshu_sw_model (.i_core_clk(clk), .i_notify_valid(nvalid),
      .i_notify_char(nchar), .o_switch(sw), .o_char_count(chars), .o_last_char(last_char));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (zero_pos === 1'b1) cnt_zero <= cnt_zero + 32'h1;
      if (stop === 1'b1) cnt_stop <= cnt_stop + 32'h1;
      if (repos === 1'b1) cnt_repos <= cnt_repos + 32'h1;
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rdv = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic expect_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, rdv, exp);
   endtask
   task automatic settle();
      repeat (30) @(posedge clk);
   endtask
   task automatic pin(input int b, input logic lvl);
      u_lshu_sw_model.set_pin(b, lvl);
      settle();
   endtask
   task automatic t_regs();
      expect_rd("direct zero", lshu_pkg::OFS_DZERO, 32'h0);
      expect_rd("direct stop", lshu_pkg::OFS_DSTOP, 32'h0);
      expect_rd("direct notify", lshu_pkg::OFS_DNOTIFY, 32'h0);
      expect_rd("unmapped", 8'h3C, 32'h0);
      bus(1'b1, lshu_pkg::OFS_POLARITY, 32'hFFFF_FFEA);
      expect_rd("polarity", lshu_pkg::OFS_POLARITY, 32'h0000_000A);
   endtask
   task automatic t_notify();
      logic [7:0] ch [5] = '{8'h68, 8'h66, 8'h74, 8'h77, 8'h78};
      bus(1'b1, lshu_pkg::OFS_POLARITY, 32'h1F);
      bus(1'b1, lshu_pkg::OFS_CTRL, 32'h1);
      bus(1'b1, lshu_pkg::OFS_DNOTIFY, 32'h1F);
      for (int b = 0; b < 5; b++) begin
         pin(b, 1'b1);
         chk("notify char", {24'h0, last_char}, {24'h0, ch[b]});
         pin(b, 1'b0);
      end
      chk("notify count", chars, 32'h5);
      expect_rd("notify cleared", lshu_pkg::OFS_DNOTIFY, 32'h0);
      pin(0, 1'b1);
      pin(0, 1'b0);
      chk("notify once", chars, 32'h5);
      bus(1'b1, lshu_pkg::OFS_CTRL, 32'h0);
      bus(1'b1, lshu_pkg::OFS_DNOTIFY, 32'h2);
      pin(1, 1'b1);
      pin(1, 1'b0);
      chk("fault not reference", chars, 32'h5);
      bus(1'b1, lshu_pkg::OFS_DNOTIFY, 32'h0);
   endtask
   task automatic t_stop_zero();
      bus(1'b1, lshu_pkg::OFS_CTRL, 32'h1);
      bus(1'b1, lshu_pkg::OFS_POLARITY, 32'h1E);
      bus(1'b1, lshu_pkg::OFS_DSTOP, 32'h1);
      pin(0, 1'b1);
      chk("stop early", cnt_stop, 32'h0);
      pin(0, 1'b0);
      chk("velocity stop", cnt_stop, 32'h1);
      chk("no repos", cnt_repos, 32'h0);
      expect_rd("stop cleared", lshu_pkg::OFS_DSTOP, 32'h0);
      bus(1'b1, lshu_pkg::OFS_CTRL, 32'h3);
      bus(1'b1, lshu_pkg::OFS_DSTOP, 32'h1);
      pin(0, 1'b1);
      pin(0, 1'b0);
      chk("position repos", cnt_repos, 32'h1);
      bus(1'b1, lshu_pkg::OFS_POLARITY, 32'h1F);
      bus(1'b1, lshu_pkg::OFS_DZERO, 32'h1);
      bus(1'b1, lshu_pkg::OFS_DZERO, 32'h4);
      pin(0, 1'b1);
      pin(0, 1'b0);
      chk("zero replaced", cnt_zero, 32'h0);
      pin(2, 1'b1);
      pin(2, 1'b0);
      chk("zero fired", cnt_zero, 32'h1);
      expect_rd("zero cleared", lshu_pkg::OFS_DZERO, 32'h0);
   endtask
   task automatic t_block();
      bus(1'b1, lshu_pkg::OFS_CTRL, 32'h1);
      bus(1'b1, lshu_pkg::OFS_BLOCK, 32'h8);
      bus(1'b1, lshu_pkg::OFS_BLKDIR, 32'hC);
      bus(1'b1, lshu_pkg::OFS_TARGET, 32'h64);
      pin(2, 1'b1);
      chk("not blocking input", {15'h0, cmd_cw, cmd_speed}, 32'h1_0064);
      pin(3, 1'b1);
      chk("cw blocked", {15'h0, cmd_cw, cmd_speed}, 32'h1_0000);
      bus(1'b1, lshu_pkg::OFS_TARGET, 32'hFFCE);
      settle();
      chk("ccw allowed", {15'h0, cmd_cw, cmd_speed}, 32'h0_0032);
      bus(1'b1, lshu_pkg::OFS_BLKDIR, 32'h0);
      settle();
      chk("ccw blocked", {16'h0, cmd_speed}, 32'h0);
      pin(3, 1'b0);
      pin(2, 1'b0);
      bus(1'b1, lshu_pkg::OFS_BLOCK, 32'h0);
      bus(1'b1, lshu_pkg::OFS_TARGET, 32'h0);
   endtask
   task automatic t_homing();
      bus(1'b1, lshu_pkg::OFS_HSPEED, 32'hFF9C);
      bus(1'b1, lshu_pkg::OFS_CMD, 32'h1);
      settle();
      chk("no action no run", {31'h0, busy}, 32'h0);
      bus(1'b1, lshu_pkg::OFS_HZERO, 32'h4);
      bus(1'b1, lshu_pkg::OFS_HSTOP, 32'h4);
      bus(1'b1, lshu_pkg::OFS_HNOTIFY, 32'h4);
      bus(1'b1, lshu_pkg::OFS_CMD, 32'h1);
      settle();
      chk("seek", {14'h0, busy, cmd_cw, cmd_speed}, 32'h2_0064);
      pin(2, 1'b1);
      chk("home zero", cnt_zero, 32'h2);
      chk("home stop", cnt_stop, 32'h2);
      chk("home char", {chars[23:0], last_char}, 32'h0000_0674);
      chk("run over", {31'h0, busy}, 32'h0);
      bus(1'b1, lshu_pkg::OFS_CMD, 32'h1);
      settle();
      chk("leave first", {14'h0, busy, cmd_cw, cmd_speed}, 32'h3_0064);
      pin(2, 1'b0);
      chk("then seek", {14'h0, busy, cmd_cw}, 32'h2);
      pin(2, 1'b1);
      chk("second stop", cnt_stop, 32'h3);
      bus(1'b1, lshu_pkg::OFS_DZERO, 32'h10);
      bus(1'b1, lshu_pkg::OFS_DSTOP, 32'h8);
      bus(1'b1, lshu_pkg::OFS_DNOTIFY, 32'h1);
      bus(1'b1, lshu_pkg::OFS_CMD, 32'h2);
      expect_rd("copy zero", lshu_pkg::OFS_HZERO, 32'h10);
      expect_rd("copy stop", lshu_pkg::OFS_HSTOP, 32'h8);
      expect_rd("copy notify", lshu_pkg::OFS_HNOTIFY, 32'h1);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_notify();
      t_stop_zero();
      t_block();
      t_homing();
      results();
   end
endmodule // testbench
`default_nettype wire
